/* hw/sofm_top.sv */
// Notes on behaviour
// - Raw and masked views of sources are readable.
// - One status bit per listed fault/event source.
// - Internal oscillator stop raises its source when enabled.
// - Internal check counts main oscillator ticks.
// - Regulator failure resets processor or is ignored.
// - Output-level code reads back as programmed.
// - Validation enable turns on main oscillator detection.
// - Fail response: interrupt when set, reset when clear.
// - No-crystal setting powers down main oscillator.
// - Main oscillator stop raises interrupt when timer enabled.
// - Main check counts internal oscillator ticks.
// - Gating select applies sleep/deep-sleep configuration.
// - Gating select clear clocks peripherals as run.
// - Writing one to a source bit clears it.
// - Disabled sources never reach the interrupt line.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sofm_top (
	input wire logic clk_i, // 200 MHz system clock
	input wire logic nrst_i, // Async reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic pll_locked_event_i, // PLL lock pulse
	input wire logic regulator_overcurrent_event_i, // Current limit pulse
	input wire logic power_on_event_i, // Power-on pulse
	input wire logic brown_out_event_i, // Brown-out pulse
	input wire logic pll_failure_event_i, // PLL failure pulse
	input wire logic internal_osc_tick_i, // One pulse per internal osc period
	input wire logic main_oscillator_tick_i, // One pulse per main osc period
	input wire logic regulator_unregulated_i, // Regulator out of regulation
	input wire logic sleep_i, // Processor in sleep
	input wire logic deep_sleep_i, // Processor in deep-sleep
	input wire logic [sofm_pkg::GATE_W-1:0] run_gate_i, // Run-mode clock enables
	input wire logic [sofm_pkg::GATE_W-1:0] sleep_gate_i, // Sleep clock enables
	input wire logic [sofm_pkg::GATE_W-1:0] deep_sleep_gate_i, // Deep-sleep clock enables
	output logic [sofm_pkg::GATE_W-1:0] periph_clk_en_o, // Peripheral clock enables
	output logic main_osc_power_down_o, // Shut down crystal oscillator
	output logic [sofm_pkg::LVL_W-1:0] regulator_level_o, // Regulator output-level code
	output logic proc_reset_req_o, // One-cycle processor reset request
	output logic irq_o // Level interrupt to processor
);
	import sofm_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic is_mapped(input logic [7:0] a);
		return a == OFS_RAW || a == OFS_ENABLE || a == OFS_MASKED ||
			a == OFS_CTRL || a == OFS_LEVEL || a == OFS_VIEW;
	endfunction

	function automatic logic [31:0] read_reg(input sofm_state_type s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		unique case (a)
			OFS_RAW: v[NSRC-1:0] = s.ris;
			OFS_ENABLE: v[NSRC-1:0] = s.ien;
			OFS_MASKED: v[NSRC-1:0] = s.ris & s.ien;
			OFS_CTRL: v[CTL_W-1:0] = s.ctl;
			OFS_LEVEL: v[LVL_W-1:0] = s.lvl;
			OFS_VIEW: v[NSRC-1:0] = s.ctl[CTL_MASKED_VIEW] ? (s.ris & s.ien) : s.ris;
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	sofm_state_type q, d;
	logic wr_go;
	logic [7:0] wa;
	logic [31:0] wd;
	logic wlane0;
	logic iosc_fail;
	logic main_osc_fail;
	logic [NSRC-1:0] set_v;
	logic [NSRC-1:0] masked_w;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		s_axi_awready = !q.aw_got && !q.bvalid;
		s_axi_wready = !q.w_got && !q.bvalid;
		s_axi_arready = !q.rvalid;
		wa = q.aw_got ? q.aw_addr : s_axi_awaddr;
		wd = q.w_got ? q.w_data : s_axi_wdata;
		wlane0 = q.w_got ? q.w_strb[0] : s_axi_wstrb[0];
		wr_go = (q.aw_got || (s_axi_awvalid && s_axi_awready)) &&
			(q.w_got || (s_axi_wvalid && s_axi_wready));
		masked_w = q.ris & q.ien;

		// Write channel capture, address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_got = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_got = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// Internal oscillator watchdog, counted in main oscillator ticks
		iosc_fail = 1'b0;
		if (!q.ctl[CTL_IOSC_TIMER] || internal_osc_tick_i) begin
			d.icnt = '0;
		end else if (main_oscillator_tick_i && q.icnt != OSC_TIMEOUT) begin
			d.icnt = q.icnt + 4'h1;
			iosc_fail = (q.icnt == OSC_TIMEOUT - 4'h1);
		end

		// Main oscillator watchdog, counted in internal oscillator ticks
		main_osc_fail = 1'b0;
		if (!(q.ctl[CTL_MAIN_OSC_CHECK] || q.ctl[CTL_MAIN_OSC_TIMER]) || main_oscillator_tick_i) begin
			d.mcnt = '0;
		end else if (internal_osc_tick_i && q.mcnt != OSC_TIMEOUT) begin
			d.mcnt = q.mcnt + 4'h1;
			main_osc_fail = (q.mcnt == OSC_TIMEOUT - 4'h1);
		end

		// Source events
		set_v = '0;
		set_v[SRC_PLL_LOCK] = pll_locked_event_i;
		set_v[SRC_OVERCURRENT] = regulator_overcurrent_event_i;
		set_v[SRC_IOSC_FAIL] = iosc_fail;
		set_v[SRC_MAIN_OSC_FAIL] = main_osc_fail &&
			(q.ctl[CTL_MAIN_OSC_IRQ_SEL] || q.ctl[CTL_MAIN_OSC_TIMER]);
		set_v[SRC_POWER_ON] = power_on_event_i;
		set_v[SRC_BROWN_OUT] = brown_out_event_i;
		set_v[SRC_PLL_FAIL] = pll_failure_event_i;

		// Processor reset request: regulator loss or main osc fail in reset mode
		d.unreg_prev = regulator_unregulated_i;
		d.rst_req = (regulator_unregulated_i && !q.unreg_prev && q.ctl[CTL_REG_RESETS]) ||
			(main_osc_fail && q.ctl[CTL_MAIN_OSC_CHECK] && !q.ctl[CTL_MAIN_OSC_IRQ_SEL] &&
			!q.ctl[CTL_MAIN_OSC_TIMER]);

		// Register writes; byte lane 0 holds every field
		if (wr_go) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
			if (wlane0) begin
				unique case (wa)
					OFS_RAW: d.ris = q.ris & ~wd[NSRC-1:0];
					OFS_ENABLE: d.ien = wd[NSRC-1:0];
					OFS_CTRL: d.ctl = wd[CTL_W-1:0];
					OFS_LEVEL: d.lvl = wd[LVL_W-1:0];
					default: d.ris = d.ris;
				endcase
			end
		end
		d.ris = d.ris | set_v;

		// Reads
		if (s_axi_arvalid && s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rdata = read_reg(q, s_axi_araddr);
			d.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// Peripheral clock gating
		if (!q.ctl[CTL_GATING_SEL]) begin
			d.clk_en = run_gate_i;
		end else if (deep_sleep_i) begin
			d.clk_en = deep_sleep_gate_i;
		end else if (sleep_i) begin
			d.clk_en = sleep_gate_i;
		end else begin
			d.clk_en = run_gate_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '{aw_got: 1'b0, w_got: 1'b0, aw_addr: 8'h00, w_data: 32'h0, w_strb: 4'h0,
				bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0,
				ris: '0, ien: '0, ctl: CTL_RST, lvl: LVL_RST, icnt: '0, mcnt: '0,
				unreg_prev: 1'b0, rst_req: 1'b0, clk_en: '0};
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign periph_clk_en_o = q.clk_en;
	assign main_osc_power_down_o = q.ctl[CTL_NO_CRYSTAL];
	assign regulator_level_o = q.lvl;
	assign proc_reset_req_o = q.rst_req;
	assign irq_o = |(q.ris & q.ien);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_raw_write;
		wr_go && wlane0 && wa == OFS_RAW;
	endsequence

	sequence s_read_masked;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_MASKED;
	endsequence

	property p_masked_view;
		s_read_masked |=> s_axi_rvalid && s_axi_rdata[NSRC-1:0] == $past(masked_w);
	endproperty
	a_masked_view: assert property (p_masked_view) else $error("masked view wrong");

	property p_sticky;
		pll_locked_event_i |=> q.ris[SRC_PLL_LOCK] ##1 (q.ris[SRC_PLL_LOCK] || $past(wr_go));
	endproperty
	a_sticky: assert property (p_sticky) else $error("source not latched");

	property p_iosc_fail;
		q.ctl[CTL_IOSC_TIMER] && !internal_osc_tick_i && main_oscillator_tick_i &&
			q.icnt == OSC_TIMEOUT - 4'h1 |=> q.ris[SRC_IOSC_FAIL];
	endproperty
	a_iosc_fail: assert property (p_iosc_fail) else $error("internal osc fail missed");

	property p_reg_reset;
		regulator_unregulated_i && !q.unreg_prev && q.ctl[CTL_REG_RESETS] |=> proc_reset_req_o ##1 !proc_reset_req_o ||
			q.ctl[CTL_MAIN_OSC_CHECK];
	endproperty
	a_reg_reset: assert property (p_reg_reset) else $error("regulator reset missing");

	property p_level_readback;
		wr_go && wlane0 && wa == OFS_LEVEL |=> regulator_level_o == $past(wd[LVL_W-1:0]);
	endproperty
	a_level_readback: assert property (p_level_readback) else $error("level not stored");

	property p_main_osc_irq;
		main_osc_fail && q.ctl[CTL_MAIN_OSC_IRQ_SEL] |=> q.ris[SRC_MAIN_OSC_FAIL] && !proc_reset_req_o;
	endproperty
	a_main_osc_irq: assert property (p_main_osc_irq) else $error("main osc irq mode wrong");

	property p_main_osc_timer;
		q.ctl[CTL_MAIN_OSC_TIMER] && !main_oscillator_tick_i && internal_osc_tick_i &&
			q.mcnt == OSC_TIMEOUT - 4'h1 |=> q.ris[SRC_MAIN_OSC_FAIL];
	endproperty
	a_main_osc_timer: assert property (p_main_osc_timer) else $error("main osc stop missed");

	property p_w1c;
		s_raw_write ##0 (wd[SRC_PLL_FAIL] && !pll_failure_event_i) |=> !q.ris[SRC_PLL_FAIL];
	endproperty
	a_w1c: assert property (p_w1c) else $error("clear did not work");

	property p_disabled_quiet;
		q.ien == '0 |-> !irq_o;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source reached irq");

	property p_run_gating;
		!q.ctl[CTL_GATING_SEL] |=> periph_clk_en_o == $past(run_gate_i);
	endproperty
	a_run_gating: assert property (p_run_gating) else $error("gating applied while off");

	property p_brown_out_latch;
		brown_out_event_i |=> q.ris[SRC_BROWN_OUT];
	endproperty
	a_brown_out_latch: assert property (p_brown_out_latch) else $error("brown-out source not latched");

	property p_deep_sleep_gating;
		q.ctl[CTL_GATING_SEL] && deep_sleep_i |=> periph_clk_en_o == $past(deep_sleep_gate_i);
	endproperty
	a_deep_sleep_gating: assert property (p_deep_sleep_gating) else $error("deep-sleep gating not applied");

	property p_main_check_off;
		!q.ctl[CTL_MAIN_OSC_CHECK] && !q.ctl[CTL_MAIN_OSC_TIMER] |=> q.mcnt == '0;
	endproperty
	a_main_check_off: assert property (p_main_check_off) else $error("main osc watchdog ran while off");

endmodule

`default_nettype wire

/* include/sofm_pkg.sv */
package sofm_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_RAW = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_MASKED = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0C;
	localparam logic [7:0] OFS_LEVEL = 8'h10;
	localparam logic [7:0] OFS_VIEW = 8'h14;

	// ------------------------------------------------------------
	// Interrupt source bit positions
	// ------------------------------------------------------------
	localparam int NSRC = 7;
	localparam int SRC_PLL_LOCK = 0;
	localparam int SRC_OVERCURRENT = 1;
	localparam int SRC_IOSC_FAIL = 2;
	localparam int SRC_MAIN_OSC_FAIL = 3;
	localparam int SRC_POWER_ON = 4;
	localparam int SRC_BROWN_OUT = 5;
	localparam int SRC_PLL_FAIL = 6;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTL_W = 8;
	localparam int CTL_MAIN_OSC_CHECK = 0;
	localparam int CTL_MAIN_OSC_IRQ_SEL = 1;
	localparam int CTL_NO_CRYSTAL = 2;
	localparam int CTL_IOSC_TIMER = 3;
	localparam int CTL_MAIN_OSC_TIMER = 4;
	localparam int CTL_REG_RESETS = 5;
	localparam int CTL_GATING_SEL = 6;
	localparam int CTL_MASKED_VIEW = 7;
	localparam logic [7:0] CTL_RST = 8'h00;

	// ------------------------------------------------------------
	// Level field, oscillator watchdog, gating, bus answers
	// ------------------------------------------------------------
	localparam int LVL_W = 4;
	localparam logic [3:0] LVL_RST = 4'h0;
	localparam int CNT_W = 4;
	localparam logic [3:0] OSC_TIMEOUT = 4'h8;
	localparam int GATE_W = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [NSRC-1:0] ris;
		logic [NSRC-1:0] ien;
		logic [CTL_W-1:0] ctl;
		logic [LVL_W-1:0] lvl;
		logic [CNT_W-1:0] icnt;
		logic [CNT_W-1:0] mcnt;
		logic unreg_prev;
		logic rst_req;
		logic [GATE_W-1:0] clk_en;
	} sofm_state_type;

endpackage

/* tb/sofm_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Oscillators and reset sink at the far side
// ------------------------------------------------------------
module sofm_osc_model (
	input wire logic clk_i, // System clock
	input wire logic nrst_i, // Reset, active low
	input wire logic int_run_i, // Internal oscillator running
	input wire logic main_run_i, // Main oscillator running
	input wire logic reset_req_i, // Reset request from block
	output logic int_tick_o, // Internal oscillator tick
	output logic main_tick_o // Main oscillator tick
);
	int ic;
	int mc;
	int n_rst = 0;
	// Both oscillators tick unless told to stop, each checks the other
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ic <= 0;
			mc <= 0;
			int_tick_o <= 1'b0;
			main_tick_o <= 1'b0;
		end else begin
			ic <= (ic + 1) % 2;
			mc <= (mc + 1) % 3;
			int_tick_o <= int_run_i && ic == 1;
			main_tick_o <= main_run_i && mc == 2;
			if (reset_req_i) n_rst <= n_rst + 1;
		end
	end
endmodule

`default_nettype wire

/* tb/sofm_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sofm_top_tb;
	import sofm_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic irq_o, proc_reset_req_o, main_osc_power_down_o, internal_osc_tick_i, main_oscillator_tick_i;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [4:0] ev = 5'h00;
	logic regulator_unregulated_i = 0, sleep_i = 0, deep_sleep_i = 0, int_run = 1, main_run = 1;
	logic [7:0] run_gate_i = 8'h00, sleep_gate_i = 8'h00, deep_sleep_gate_i = 8'h00, periph_clk_en_o;
	logic [3:0] regulator_level_o;
	int n_errors = 0;
	int n_checks = 0;
	int pos[5] = '{SRC_PLL_LOCK, SRC_OVERCURRENT, SRC_POWER_ON, SRC_BROWN_OUT, SRC_PLL_FAIL};

	sofm_top dut (.clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_locked_event_i(ev[0]),
		.regulator_overcurrent_event_i(ev[1]), .power_on_event_i(ev[2]), .brown_out_event_i(ev[3]),
		.pll_failure_event_i(ev[4]), .internal_osc_tick_i, .main_oscillator_tick_i, .regulator_unregulated_i,
		.sleep_i, .deep_sleep_i, .run_gate_i, .sleep_gate_i, .deep_sleep_gate_i, .periph_clk_en_o,
		.main_osc_power_down_o, .regulator_level_o, .proc_reset_req_o, .irq_o);
	sofm_osc_model pm (.clk_i, .nrst_i, .int_run_i(int_run), .main_run_i(main_run),
		.reset_req_i(proc_reset_req_o), .int_tick_o(internal_osc_tick_i), .main_tick_o(main_oscillator_tick_i));

	always #2.5 clk_i = ~clk_i;

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic results;
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang(input string nm);
		chk(nm, 32'h0, 32'h1);
		results();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int i;
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(negedge clk_i);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_i);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
		end
		if (i == 40) hang("write wait");
		chk("bresp", r, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		int i;
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(negedge clk_i);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_i);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) break;
		end
		if (i == 40) hang("read wait");
		chk("rdata", d, e);
		chk("rresp", r, er);
	endtask
	task automatic pulse(input int k);
		@(posedge clk_i);
		ev[k] <= 1'b1;
		@(posedge clk_i);
		ev[k] <= 1'b0;
	endtask
	task automatic irq_is(input logic e);
		@(negedge clk_i);
		chk("irq", irq_o, e);
	endtask
	task automatic run(input logic i, input logic m);
		@(posedge clk_i);
		int_run <= i;
		main_run <= m;
	endtask
	task automatic wait_irq;
		int i;
		for (i = 0; i < 100; i++) begin
			@(negedge clk_i);
			if (irq_o === 1'b1) break;
		end
		if (i == 100) hang("irq wait");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd(OFS_RAW, 32'h0);
		rd(OFS_CTRL, CTL_RST);
		rd(OFS_LEVEL, LVL_RST);
		rd(8'h18, 32'h0, RESP_SLVERR);
		wr(8'h18, 32'h7F, RESP_SLVERR);
		wr(OFS_MASKED, 32'h7F);
		rd(OFS_MASKED, 32'h0);
	endtask
	task automatic t_events;
		logic [31:0] b;
		for (int k = 0; k < 5; k++) begin
			b = 32'h1 << pos[k];
			pulse(k);
			rd(OFS_RAW, b);
			irq_is(1'b0);
			wr(OFS_ENABLE, b);
			irq_is(1'b1);
			rd(OFS_MASKED, b);
			wr(OFS_RAW, b);
			irq_is(1'b0);
			wr(OFS_ENABLE, 32'h0);
		end
		pulse(0);
		pulse(1);
		wr(OFS_ENABLE, 32'h1);
		rd(OFS_VIEW, 32'h3);
		wr(OFS_CTRL, 32'h80);
		rd(OFS_VIEW, 32'h1);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_RAW, 32'h7F);
		rd(OFS_RAW, 32'h0);
	endtask
	task automatic t_osc;
		logic [7:0] cs[2] = '{8'h10, 8'h03};
		int n0;
		wr(OFS_CTRL, 32'h19);
		repeat (60) @(posedge clk_i);
		rd(OFS_RAW, 32'h0);
		wr(OFS_ENABLE, 32'h1 << SRC_IOSC_FAIL);
		run(1'b0, 1'b1);
		wait_irq();
		rd(OFS_RAW, 32'h1 << SRC_IOSC_FAIL);
		wr(OFS_CTRL, 32'h0);
		run(1'b1, 1'b1);
		wr(OFS_RAW, 32'h7F);
		wr(OFS_ENABLE, 32'h1 << SRC_MAIN_OSC_FAIL);
		foreach (cs[j]) begin
			wr(OFS_CTRL, cs[j]);
			run(1'b1, 1'b0);
			wait_irq();
			rd(OFS_RAW, 32'h1 << SRC_MAIN_OSC_FAIL);
			wr(OFS_CTRL, 32'h0);
			run(1'b1, 1'b1);
			wr(OFS_RAW, 32'h7F);
		end
		n0 = pm.n_rst;
		wr(OFS_CTRL, 32'h01);
		run(1'b1, 1'b0);
		repeat (60) @(posedge clk_i);
		rd(OFS_RAW, 32'h0);
		chk("reset count", pm.n_rst > n0, 32'h1);
		wr(OFS_CTRL, 32'h0);
		run(1'b1, 1'b1);
	endtask
	task automatic t_misc;
		logic [7:0] cs[2] = '{8'h20, 8'h00};
		int n0;
		foreach (cs[j]) begin
			wr(OFS_CTRL, cs[j]);
			n0 = pm.n_rst;
			@(posedge clk_i);
			regulator_unregulated_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			chk("reset count", pm.n_rst - n0, 32'(j == 0));
			regulator_unregulated_i <= 1'b0;
		end
		wr(OFS_CTRL, 32'h04);
		@(negedge clk_i);
		chk("power down", main_osc_power_down_o, 32'h1);
		wr(OFS_LEVEL, 32'hA);
		rd(OFS_LEVEL, 32'hA);
		chk("level", regulator_level_o, 32'hA);
		run_gate_i <= 8'h5A;
		sleep_gate_i <= 8'h3C;
		deep_sleep_gate_i <= 8'hC3;
		sleep_i <= 1'b1;
		wr(OFS_CTRL, 32'h0);
		@(negedge clk_i);
		chk("gate", periph_clk_en_o, 32'h5A);
		chk("power down", main_osc_power_down_o, 32'h0);
		wr(OFS_CTRL, 32'h40);
		@(negedge clk_i);
		chk("gate", periph_clk_en_o, 32'h3C);
		@(posedge clk_i);
		deep_sleep_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk("gate", periph_clk_en_o, 32'hC3);
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_events();
		t_osc();
		t_misc();
		results();
	end
endmodule

`default_nettype wire
